// ==== verilog/rf_mode_and_wideband_pll_acq.sv ====
// Function
// RL1 - standby enables both synthesizer loops and oscillators, no tx or rx
// RL2 - loops lock within 150 us after standby; lock detect then asserts
// RL3 - controller should hold standby while locking, after reprogram, sleep
// RL4 - words C and D set first and second oscillator divide ratios
// RL5 - on transmit select, clamp wideband pump midrail 0.25 or 0.2 us
// RL6 - after clamp, frequency detector drives loop 1 or 0.8 us
// RL7 - then, if word B bit 11 low, xor detector until deselect
// RL8 - tx down-converter and wideband loop on only in transmit mode
// RL9 - wideband loop gives a frequency lock indication output
// RL10 - receive mode keeps every transmitter section disabled
// RL11 - serial words load into latches in every operating mode
// RL12 - reference divider ratios 40, 32, 20, 16 feed both detectors
// RL13 - charge pump polarity and magnitude programmable over serial bus
// RL14 - standby adds 8 or 10 MHz calibration tone to second oscillator
// RL15 - sleep powers down all but interface and held registers
// RL16 - serial mode settings override the parallel mode lines
// RL17 - shift while latch enable low, load on its rising edge
// RL18 - acquisition intervals count reference cycles, per reference group
// RL19 - transmit deselect aborts acquisition back to idle
`timescale 1ns/1ps
`default_nettype none

module rf_mode_and_wideband_pll_acq #(
    parameter int LOCK_WAIT = rf_mode_pkg::LOCK_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic transmit_select_n,
    input wire logic receive_select_n,
    input wire logic oscillator_enable_n,
    input wire rf_mode_pkg::serial_s serial_in,
    input wire logic ref_in,
    input wire logic lo_loops_locked,
    input wire logic wideband_freq_lock,
    output logic [rf_mode_pkg::DATA_W-1:0] first_lo_divide,
    output logic [rf_mode_pkg::DATA_W-1:0] second_lo_divide,
    output logic [1:0] ref_divide_sel,
    output rf_mode_pkg::cp_cfg_s first_lo_pump_out,
    output logic [rf_mode_pkg::DAC_W-1:0] dac_value,
    output rf_mode_pkg::op_mode_e op_mode,
    output rf_mode_pkg::section_en_s section_en,
    output rf_mode_pkg::wb_pump_s wideband_pump_out,
    output logic lock_detect_out,
    output logic wideband_lock_out,
    output logic cal_tone_out
);
    import rf_mode_pkg::*;

    if (LOCK_WAIT < 1 || LOCK_WAIT >= (1 << LOCK_W)) begin : g_bad_lock
        $error("LOCK_WAIT does not fit the lock counter");
    end

    typedef struct packed {
        serial_s ser_prev;
        logic ref_prev;
        logic [WORD_W-1:0] shift;
        logic [DATA_W-1:0] word_a;
        logic [DATA_W-1:0] word_b;
        logic [DATA_W-1:0] word_c;
        logic [DATA_W-1:0] word_d;
        logic [DATA_W-1:0] word_e;
        logic [DAC_W-1:0] dac;
        op_mode_e mode;
        section_en_s en;
        acq_state_e acq;
        logic [ACQ_W-1:0] acq_cnt;
        wb_pump_s pump;
        logic [LOCK_W-1:0] lock_cnt;
        logic lock_det;
        logic wb_lock;
        logic [1:0] tone_cnt;
        logic tone;
    } state_s;

    state_s s_q;
    state_s s_d;

    // ------------------------------------------------------------
    // decoded helpers
    // ------------------------------------------------------------
    logic ser_rise;
    logic en_rise;
    logic conv_rise;
    logic ref_rise;
    logic [ADDR_W-1:0] sh_addr;
    logic [DATA_W-1:0] sh_data;
    op_mode_e pin_mode;
    op_mode_e next_mode;
    logic [1:0] rsel;
    logic [ACQ_W-1:0] clamp_refs;
    logic [ACQ_W-1:0] pfd_refs;
    logic [1:0] tone_half;
    logic divider_written;

    assign ser_rise = serial_in.ser_clk & ~s_q.ser_prev.ser_clk;
    assign en_rise = serial_in.ser_en_n & ~s_q.ser_prev.ser_en_n;
    assign conv_rise = serial_in.conv_en_n & ~s_q.ser_prev.conv_en_n;
    assign ref_rise = ref_in & ~s_q.ref_prev;
    assign sh_addr = s_q.shift[ADDR_W-1:0];
    assign sh_data = s_q.shift[WORD_W-1:ADDR_W];
    assign rsel = s_q.word_a[A_REFSEL_HI:A_REFSEL_LO];
    assign divider_written = en_rise &&
        (sh_addr == ADDR_WORD_C || sh_addr == ADDR_WORD_D);

    // parallel lines: high oscillator enable means sleep
    always_comb begin
        if (oscillator_enable_n) begin
            pin_mode = MODE_SLEEP;
        end else if (!receive_select_n && transmit_select_n) begin
            pin_mode = MODE_RECEIVE;
        end else if (receive_select_n && !transmit_select_n) begin
            pin_mode = MODE_TRANSMIT;
        end else begin
            pin_mode = MODE_STANDBY;
        end
    end

    always_comb begin
        if (s_q.word_a[A_OVR_BIT]) begin
            next_mode = op_mode_e'(s_q.word_a[A_MODE_HI:A_MODE_LO]); // RL16
        end else begin
            next_mode = pin_mode;
        end
    end

    // interval lengths picked by the reference group
    always_comb begin
        case (rsel) // RL18
            2'h0: begin
                clamp_refs = CLAMP_REFS_40;
                pfd_refs = PFD_REFS_40;
                tone_half = TONE_HALF_40;
            end
            2'h1: begin
                clamp_refs = CLAMP_REFS_32;
                pfd_refs = PFD_REFS_32;
                tone_half = TONE_HALF_32;
            end
            2'h2: begin
                clamp_refs = CLAMP_REFS_20;
                pfd_refs = PFD_REFS_20;
                tone_half = TONE_HALF_20;
            end
            default: begin
                clamp_refs = CLAMP_REFS_16;
                pfd_refs = PFD_REFS_16;
                tone_half = TONE_HALF_16;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ser_prev = serial_in;
        s_d.ref_prev = ref_in;

        // serial bus runs in every mode, sleep included
        if (ser_rise && (!serial_in.ser_en_n || !serial_in.conv_en_n)) begin
            s_d.shift = {s_q.shift[WORD_W-2:0], serial_in.ser_data}; // RL17
        end
        if (en_rise) begin // RL11
            case (sh_addr) // RL17
                ADDR_WORD_A: s_d.word_a = sh_data; // RL13
                ADDR_WORD_B: s_d.word_b = sh_data;
                ADDR_WORD_C: s_d.word_c = sh_data; // RL4
                ADDR_WORD_D: s_d.word_d = sh_data; // RL4
                ADDR_WORD_E: s_d.word_e = sh_data;
                default: s_d.word_e = s_q.word_e;
            endcase
        end
        if (conv_rise) begin
            s_d.dac = sh_data[DAC_W-1:0]; // RL11
        end

        s_d.mode = next_mode;
        s_d.en = '0; // RL15
        case (next_mode)
            MODE_STANDBY: begin
                s_d.en.first_lo_en = 1'b1; // RL1
                s_d.en.second_lo_en = 1'b1; // RL1
                s_d.en.osc_en = 1'b1; // RL1
            end
            MODE_RECEIVE: begin
                s_d.en.first_lo_en = 1'b1;
                s_d.en.second_lo_en = 1'b1;
                s_d.en.osc_en = 1'b1;
                s_d.en.rx_conv_en = ~s_q.word_e[E_RX_OFF_BIT]; // RL10
            end
            MODE_TRANSMIT: begin
                s_d.en.first_lo_en = 1'b1;
                s_d.en.second_lo_en = 1'b1;
                s_d.en.osc_en = 1'b1;
                s_d.en.tx_conv_en = ~s_q.word_e[E_TX_OFF_BIT]; // RL8
                s_d.en.wideband_en = ~s_q.word_e[E_WB_OFF_BIT]; // RL8
            end
            default: s_d.en = '0; // RL15
        endcase

        // lock timer restarts on sleep and on divider rewrites
        if (next_mode == MODE_SLEEP || divider_written) begin
            s_d.lock_cnt = '0;
            s_d.lock_det = 1'b0;
        end else begin
            if (s_q.lock_cnt < LOCK_W'(LOCK_WAIT)) begin
                s_d.lock_cnt = s_q.lock_cnt + LOCK_W'(1);
            end
            s_d.lock_det = lo_loops_locked ||
                (s_q.lock_cnt >= LOCK_W'(LOCK_WAIT)); // RL2
        end

        // wideband acquisition, timed in reference cycles
        if (ref_rise && s_q.acq_cnt != '0) begin
            s_d.acq_cnt = s_q.acq_cnt - ACQ_W'(1); // RL18
        end
        if (!s_d.en.wideband_en) begin
            s_d.acq = ACQ_IDLE; // RL19
            s_d.acq_cnt = '0;
        end else begin
            case (s_q.acq)
                ACQ_IDLE: begin
                    s_d.acq = ACQ_CLAMP; // RL5
                    s_d.acq_cnt = clamp_refs; // RL5
                end
                ACQ_CLAMP: begin
                    if (s_d.acq_cnt == '0) begin
                        s_d.acq = ACQ_PFD; // RL6
                        s_d.acq_cnt = pfd_refs; // RL6
                    end
                end
                ACQ_PFD: begin
                    // with bit 11 high the detector stays in pfd
                    if (s_d.acq_cnt == '0 &&
                        !s_q.word_b[B_XOR_OFF_BIT]) begin
                        s_d.acq = ACQ_XOR; // RL7
                    end
                end
                ACQ_XOR: s_d.acq = ACQ_XOR; // RL7
                default: s_d.acq = ACQ_IDLE;
            endcase
        end
        s_d.pump.clamp = (s_d.acq == ACQ_CLAMP); // RL5
        s_d.pump.pfd_en = (s_d.acq == ACQ_PFD); // RL6
        s_d.pump.xor_en = (s_d.acq == ACQ_XOR); // RL7
        // lock is only meaningful once the clamp has let go
        s_d.wb_lock = wideband_freq_lock &&
            (s_d.acq == ACQ_PFD || s_d.acq == ACQ_XOR); // RL9

        // calibration tone derived from the reference itself
        if (next_mode == MODE_STANDBY && !s_q.word_e[E_CAL_OFF_BIT]) begin
            if (ref_rise) begin
                if (s_q.tone_cnt + 2'h1 >= tone_half) begin
                    s_d.tone_cnt = 2'h0;
                    s_d.tone = ~s_q.tone; // RL14
                end else begin
                    s_d.tone_cnt = s_q.tone_cnt + 2'h1;
                end
            end
        end else begin
            s_d.tone_cnt = 2'h0;
            s_d.tone = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.ser_prev <= '1;
            s_q.word_a <= WORD_RESET;
            s_q.word_b <= WORD_RESET;
            s_q.word_c <= WORD_RESET;
            s_q.word_d <= WORD_RESET;
            s_q.word_e <= WORD_RESET;
            s_q.dac <= DAC_RESET;
            s_q.mode <= MODE_SLEEP;
            s_q.acq <= ACQ_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign first_lo_divide = s_q.word_c; // RL4
    assign second_lo_divide = s_q.word_d; // RL4
    assign ref_divide_sel = rsel; // RL12
    assign first_lo_pump_out.polarity = s_q.word_a[A_CP_POL_BIT]; // RL13
    assign first_lo_pump_out.magnitude =
        s_q.word_a[A_CP_MAG_HI:A_CP_MAG_LO]; // RL13
    assign dac_value = s_q.dac;
    assign op_mode = s_q.mode;
    assign section_en = s_q.en;
    assign wideband_pump_out = s_q.pump;
    assign lock_detect_out = s_q.lock_det;
    assign wideband_lock_out = s_q.wb_lock;
    assign cal_tone_out = s_q.tone;

endmodule : rf_mode_and_wideband_pll_acq

`default_nettype wire

// ==== include/rf_mode_pkg.sv ====
package rf_mode_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_MHZ = 200;
    localparam int LOCK_TIME_US = 150;
    localparam int LOCK_CYCLES = LOCK_TIME_US * MCLK_MHZ;
    localparam int LOCK_W = 20;

    localparam int CLAMP_NS_LOW = 250;
    localparam int CLAMP_NS_HIGH = 200;
    localparam int PFD_NS_LOW = 1000;
    localparam int PFD_NS_HIGH = 800;

    // reference frequency for each divider select code
    localparam int REF_MHZ_SEL0 = 40;
    localparam int REF_MHZ_SEL1 = 32;
    localparam int REF_MHZ_SEL2 = 20;
    localparam int REF_MHZ_SEL3 = 16;
    localparam int TONE_MHZ_LOW = 8;
    localparam int TONE_MHZ_HIGH = 10;

    localparam int ACQ_W = 6;
    localparam logic [ACQ_W-1:0] CLAMP_REFS_40 =
        ACQ_W'(CLAMP_NS_HIGH * REF_MHZ_SEL0 / 1000);
    localparam logic [ACQ_W-1:0] CLAMP_REFS_32 =
        ACQ_W'(CLAMP_NS_LOW * REF_MHZ_SEL1 / 1000);
    localparam logic [ACQ_W-1:0] CLAMP_REFS_20 =
        ACQ_W'(CLAMP_NS_HIGH * REF_MHZ_SEL2 / 1000);
    localparam logic [ACQ_W-1:0] CLAMP_REFS_16 =
        ACQ_W'(CLAMP_NS_LOW * REF_MHZ_SEL3 / 1000);
    localparam logic [ACQ_W-1:0] PFD_REFS_40 =
        ACQ_W'(PFD_NS_HIGH * REF_MHZ_SEL0 / 1000);
    localparam logic [ACQ_W-1:0] PFD_REFS_32 =
        ACQ_W'(PFD_NS_LOW * REF_MHZ_SEL1 / 1000);
    localparam logic [ACQ_W-1:0] PFD_REFS_20 =
        ACQ_W'(PFD_NS_HIGH * REF_MHZ_SEL2 / 1000);
    localparam logic [ACQ_W-1:0] PFD_REFS_16 =
        ACQ_W'(PFD_NS_LOW * REF_MHZ_SEL3 / 1000);
    // reference rising edges per half period of the tone
    localparam logic [1:0] TONE_HALF_40 =
        2'(REF_MHZ_SEL0 / (2 * TONE_MHZ_HIGH));
    localparam logic [1:0] TONE_HALF_32 =
        2'(REF_MHZ_SEL1 / (2 * TONE_MHZ_LOW));
    localparam logic [1:0] TONE_HALF_20 =
        2'(REF_MHZ_SEL2 / (2 * TONE_MHZ_HIGH));
    localparam logic [1:0] TONE_HALF_16 =
        2'(REF_MHZ_SEL3 / (2 * TONE_MHZ_LOW));

    // ------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int DATA_W = 13;
    localparam int ADDR_W = 3;
    localparam int DAC_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_WORD_A = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_WORD_B = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_WORD_C = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_WORD_D = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_WORD_E = 3'h4;
    localparam logic [DATA_W-1:0] WORD_RESET = 13'h0000;
    localparam logic [DAC_W-1:0] DAC_RESET = 8'h00;

    // word A fields
    localparam int A_OVR_BIT = 12;
    localparam int A_MODE_HI = 11;
    localparam int A_MODE_LO = 10;
    localparam int A_CP_MAG_HI = 5;
    localparam int A_CP_MAG_LO = 3;
    localparam int A_CP_POL_BIT = 2;
    localparam int A_REFSEL_HI = 1;
    localparam int A_REFSEL_LO = 0;
    // word B field
    localparam int B_XOR_OFF_BIT = 11;
    // word E fields: per-section disables
    localparam int E_RX_OFF_BIT = 0;
    localparam int E_TX_OFF_BIT = 1;
    localparam int E_WB_OFF_BIT = 2;
    localparam int E_CAL_OFF_BIT = 3;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_RECEIVE,
        MODE_TRANSMIT
    } op_mode_e;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_CLAMP,
        ACQ_PFD,
        ACQ_XOR
    } acq_state_e;

    typedef struct packed {
        logic first_lo_en;
        logic second_lo_en;
        logic osc_en;
        logic rx_conv_en;
        logic tx_conv_en;
        logic wideband_en;
    } section_en_s;

    typedef struct packed {
        logic clamp;
        logic pfd_en;
        logic xor_en;
    } wb_pump_s;

    typedef struct packed {
        logic polarity;
        logic [2:0] magnitude;
    } cp_cfg_s;

    typedef struct packed {
        logic ser_clk;
        logic ser_data;
        logic ser_en_n;
        logic conv_en_n;
    } serial_s;

endpackage : rf_mode_pkg

// ==== verif/rf_mode_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rf_mode_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wideband_freq_lock,
    input wire rf_mode_pkg::op_mode_e op_mode,
    input wire rf_mode_pkg::section_en_s section_en,
    input wire rf_mode_pkg::wb_pump_s wideband_pump_out,
    input wire logic wideband_lock_out,
    input wire logic cal_tone_out
);
    import rf_mode_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // section enables per mode
    // ------------------------------------------------------------
    AST_SLEEP_OFF: assert property (op_mode == MODE_SLEEP |->
        section_en == 6'h00) else $error("section on in sleep");
    AST_STANDBY_SET: assert property (op_mode == MODE_STANDBY |->
        section_en == 6'h38) else $error("standby enables wrong");
    AST_TX_ONLY: assert property (section_en.tx_conv_en ||
        section_en.wideband_en |-> op_mode == MODE_TRANSMIT)
        else $error("tx section on outside transmit");
    AST_RX_QUIET: assert property (op_mode == MODE_RECEIVE |->
        !section_en.tx_conv_en && !section_en.wideband_en)
        else $error("tx section on in receive");
    // ------------------------------------------------------------
    // acquisition sequence
    // ------------------------------------------------------------
    AST_CLAMP_START: assert property ($rose(section_en.wideband_en)
        |-> ##[0:2] wideband_pump_out == 3'h4)
        else $error("clamp did not start");
    AST_PFD_AFTER: assert property ($fell(wideband_pump_out.clamp) &&
        section_en.wideband_en |-> wideband_pump_out == 3'h2)
        else $error("clamp not followed by pfd");
    AST_XOR_AFTER_PFD: assert property ($rose(wideband_pump_out.xor_en)
        |-> $past(wideband_pump_out.pfd_en))
        else $error("xor without pfd");
    AST_ONEHOT: assert property ($onehot0(wideband_pump_out))
        else $error("pump phases overlap");
    AST_IDLE_PUMP: assert property (!section_en.wideband_en ##1
        !section_en.wideband_en |-> wideband_pump_out == 3'h0)
        else $error("pump active while idle");
    // tone only stands in standby; one cycle of grace on the way out
    AST_TONE_STANDBY: assert property (op_mode != MODE_STANDBY ##1
        op_mode != MODE_STANDBY |-> !cal_tone_out)
        else $error("tone outside standby");
    // lock and phase are registered together, so the phase is the current one
    AST_WB_LOCK: assert property (wideband_lock_out |->
        $past(wideband_freq_lock) && (wideband_pump_out.pfd_en ||
        wideband_pump_out.xor_en)) else $error("lock out without cause");
endmodule : rf_mode_chk
bind rf_mode_and_wideband_pll_acq rf_mode_chk i_chk (
    .mclk(mclk), .sys_rst(sys_rst), .wideband_freq_lock(wideband_freq_lock),
    .op_mode(op_mode), .section_en(section_en),
    .wideband_pump_out(wideband_pump_out),
    .wideband_lock_out(wideband_lock_out), .cal_tone_out(cal_tone_out)
);
`default_nettype wire

// ==== verif/rf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rf_host_model (
    input wire logic mclk,
    output var rf_mode_pkg::serial_s ser
);
    import rf_mode_pkg::*;
    initial begin
        ser = 4'b0011;
    end
    // ------------------------------------------------------------
    // serial sender: every level held two mclk so sampling sees it
    // ------------------------------------------------------------
    task automatic hold2();
        repeat (2) @(negedge mclk);
    endtask : hold2
    task automatic send(input logic [WORD_W-1:0] w, input logic to_dac);
        ser.conv_en_n = !to_dac;
        ser.ser_en_n = to_dac;
        hold2();
        for (int i = WORD_W - 1; i >= 0; i--) begin
            ser.ser_data = w[i];
            hold2();
            ser.ser_clk = 1'b1;
            hold2();
            ser.ser_clk = 1'b0;
        end
        hold2();
        ser.ser_en_n = 1'b1;
        ser.conv_en_n = 1'b1;
        ser.ser_data = !w[0];
        hold2();
        hold2();
    endtask : send
endmodule : rf_host_model
`default_nettype wire

// ==== verif/rf_mode_and_wideband_pll_acq_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rf_mode_and_wideband_pll_acq_test;
    import rf_mode_pkg::*;
    localparam int LW = 50;
    localparam int MHZ [4] = '{40, 32, 20, 16};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic transmit_select_n = 1'b1;
    logic receive_select_n = 1'b1;
    logic oscillator_enable_n = 1'b1;
    logic ref_in = 1'b0;
    logic ref_q = 1'b0;
    logic lo_loops_locked = 1'b0;
    logic wideband_freq_lock = 1'b0;
    logic [31:0] seed = 32'h1C7F5E13;
    logic [DATA_W-1:0] first_lo_divide, second_lo_divide;
    logic [1:0] ref_divide_sel;
    logic [DAC_W-1:0] dac_value;
    logic lock_detect_out, wideband_lock_out, cal_tone_out;
    serial_s ser;
    cp_cfg_s first_lo_pump_out;
    op_mode_e op_mode;
    section_en_s section_en;
    wb_pump_s wideband_pump_out;
    int errors = 0;
    int checks = 0;
    int refp = 8;
    int rcnt = 0;
    int rises = 0;
    rf_host_model i_host (.mclk(mclk), .ser(ser));
    rf_mode_and_wideband_pll_acq #(.LOCK_WAIT(LW)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst),
        .transmit_select_n(transmit_select_n),
        .receive_select_n(receive_select_n),
        .oscillator_enable_n(oscillator_enable_n), .serial_in(ser),
        .ref_in(ref_in), .lo_loops_locked(lo_loops_locked),
        .wideband_freq_lock(wideband_freq_lock),
        .first_lo_divide(first_lo_divide),
        .second_lo_divide(second_lo_divide),
        .ref_divide_sel(ref_divide_sel),
        .first_lo_pump_out(first_lo_pump_out), .dac_value(dac_value),
        .op_mode(op_mode), .section_en(section_en),
        .wideband_pump_out(wideband_pump_out),
        .lock_detect_out(lock_detect_out),
        .wideband_lock_out(wideband_lock_out), .cal_tone_out(cal_tone_out)
    );
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // reference clock; frequencies keep the 40:32:20:16 proportions
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        rcnt = (rcnt + 1) % refp;
        ref_in = (rcnt < refp / 2);
    end
    always @(posedge mclk) begin
        ref_q <= ref_in;
        if (ref_in && !ref_q)
            rises <= rises + 1;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // reference edges in a span of ns_lo (16/32 MHz) or ns_hi (20/40 MHz)
    function automatic int exp_refs(input logic [1:0] sel, input int ns_lo,
                                    input int ns_hi);
        return ((MHZ[sel] % 10 == 0) ? ns_hi : ns_lo) * MHZ[sel] / 1000;
    endfunction : exp_refs
    function automatic logic [15:0] word_a(input logic ovr,
        input logic [1:0] m, input logic [2:0] mag, input logic pol,
        input logic [1:0] sel);
        return {ovr, m, 4'h0, mag, pol, sel, ADDR_WORD_A};
    endfunction : word_a
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic set_mode(input op_mode_e m);
        @(negedge mclk);
        oscillator_enable_n = (m == MODE_SLEEP);
        receive_select_n = (m != MODE_RECEIVE);
        transmit_select_n = (m != MODE_TRANSMIT);
    endtask : set_mode
    task automatic acq(input logic [1:0] sel, input logic xoff);
        int nc, np, nx, last, ph, k, n;
        logic tone;
        seed = xorshift(seed);
        refp = 320 / MHZ[sel];
        i_host.send(word_a(1'b0, 2'h0, seed[2:0], seed[3], sel), 1'b0);
        check(ref_divide_sel, sel);
        check(first_lo_pump_out, seed[3:0]);
        i_host.send({seed[12], xoff, seed[15:5], ADDR_WORD_B}, 1'b0);
        set_mode(MODE_STANDBY);
        tone = cal_tone_out;
        k = 0;
        n = 0;
        last = rises;
        while (k < 4 && n < 400) begin
            @(negedge mclk);
            n++;
            if (cal_tone_out !== tone) begin
                tone = cal_tone_out;
                if (k > 0)
                    check(rises - last, exp_refs(sel, 125, 100) / 2);
                last = rises;
                k++;
            end
        end
        check(k, 4);
        while (rises == last) @(negedge mclk);
        wideband_freq_lock = 1'b1;
        set_mode(MODE_TRANSMIT);
        nc = 0;
        np = 0;
        nx = 0;
        ph = 0;
        last = rises;
        // edges are credited to the phase seen before them
        repeat (48 * refp) begin
            @(negedge mclk);
            if (ph == 1)
                nc += rises - last;
            if (ph == 2)
                np += rises - last;
            last = rises;
            ph = wideband_pump_out.clamp ? 1 : wideband_pump_out.pfd_en ? 2 :
                 wideband_pump_out.xor_en ? 3 : 0;
            nx += (ph == 3);
        end
        check(nc, exp_refs(sel, 250, 200));
        if (!xoff)
            check(np, exp_refs(sel, 1000, 800));
        check(nx > 0, !xoff);
        check(wideband_lock_out, 1'b1);
        check(section_en, 6'h3B);
        set_mode(MODE_STANDBY);
        wideband_freq_lock = 1'b0;
        repeat (2) @(negedge mclk);
        check({section_en, wideband_pump_out}, {6'h38, 3'h0});
    endtask : acq
    initial begin
        #200000;
        errors++;
        final_report();
    end
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        check({op_mode, section_en, wideband_pump_out, lock_detect_out,
               cal_tone_out, dac_value}, 32'h0);
        seed = xorshift(seed);
        i_host.send({seed[12:0], ADDR_WORD_D}, 1'b0);
        check(second_lo_divide, seed[12:0]);
        i_host.send({~seed[12:0], 3'h5}, 1'b0);
        check(second_lo_divide, seed[12:0]);
        i_host.send({seed[28:16], seed[2:0]}, 1'b1);
        check(dac_value, seed[23:16]);
        set_mode(MODE_STANDBY);
        repeat (LW - 5) @(negedge mclk);
        check(lock_detect_out, 1'b0);
        repeat (10) @(negedge mclk);
        check(lock_detect_out, 1'b1);
        i_host.send({seed[31:19], ADDR_WORD_C}, 1'b0);
        check(first_lo_divide, seed[31:19]);
        check(lock_detect_out, 1'b0);
        lo_loops_locked = 1'b1;
        repeat (3) @(negedge mclk);
        check(lock_detect_out, 1'b1);
        lo_loops_locked = 1'b0;
        set_mode(MODE_SLEEP);
        i_host.send(word_a(1'b1, 2'h3, 3'h0, 1'b0, 2'h0), 1'b0);
        check(op_mode, MODE_TRANSMIT);
        i_host.send(word_a(1'b0, 2'h0, 3'h0, 1'b0, 2'h0), 1'b0);
        check(op_mode, MODE_SLEEP);
        for (int s = 0; s < 4; s++) begin
            acq(2'(s), 1'b0);
            acq(2'(s), 1'b1);
        end
        set_mode(MODE_TRANSMIT);
        repeat (3) @(negedge mclk);
        check(wideband_pump_out, 3'h4);
        set_mode(MODE_RECEIVE);
        repeat (2) @(negedge mclk);
        check({section_en, wideband_pump_out}, {6'h3C, 3'h0});
        // word E: receive converter and wideband loop switched off
        i_host.send({13'h0005, ADDR_WORD_E}, 1'b0);
        check(section_en, 6'h38);
        set_mode(MODE_TRANSMIT);
        repeat (3) @(negedge mclk);
        check({section_en, wideband_pump_out}, {6'h3A, 3'h0});
        final_report();
    end
endmodule : rf_mode_and_wideband_pll_acq_test
`default_nettype wire
